// ---- pkg/sdram_mode_cfg.svh ----
// offsets, field positions, reset values and timing counts of the mode-register link
`ifndef SDRAM_MODE_CFG_SVH
`define SDRAM_MODE_CFG_SVH

`define CLK_PERIOD_PS 5000
`define CEIL_CK(ps) (((ps) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`define MODE_W 19
`define ADDR_W 19
`define COL_W 6
`define DQ_W 8
`define MODE_RESET 19'h00000
`define RSVD_MASK 19'h4E080

`define BL_MSB 1
`define BL_LSB 0
`define BL_FIXED8 2'h0
`define BL_OTF 2'h1
`define BL_CHOP4 2'h2
`define BT_BIT 3
`define CL_LO_BIT 2
`define CL_MSB 6
`define CL_LSB 4
`define DLL_RST_BIT 8
`define WR_MSB 11
`define WR_LSB 9
`define PPD_BIT 12
`define CHOP_ADDR_BIT 12

`define MRD_CK 4
`define MOD_CK 12
`define MRSPDEN_CK 12
`define DLLK_CK 512
`define XPDLL_PS 24000
`define XP_PS 6000
`define RP_PS 13750
`define WR_PS 15000
`define XPDLL_CK `CEIL_CK(`XPDLL_PS)
`define XP_CK `CEIL_CK(`XP_PS)
`define RP_CK `CEIL_CK(`RP_PS)
`define WR_CK `CEIL_CK(`WR_PS)
`define GAP_CL_CK ((`XPDLL_CK > `MOD_CK) ? `XPDLL_CK : `MOD_CK)

`define OFF_MODE 8'h00
`define OFF_COL 8'h04
`define OFF_CTRL 8'h08
`define OFF_STAT 8'h0C
`define OFF_WLO 8'h10
`define OFF_WHI 8'h14
`define OFF_RLO 8'h18
`define OFF_RHI 8'h1C
`define MODE_BA_LSB 20
`define CTRL_CKE_BIT 4
`define CTRL_RST_BIT 5
`define PEND_MRS 0
`define PEND_RD 1
`define PEND_WR 2
`define PEND_ZQ 3

`endif

// ---- pkg/sdram_mode_pkg.sv ----
// types shared by the controller and the device of the mode-register link
`include "sdram_mode_cfg.svh"
package sdram_mode_pkg;

  typedef enum logic [2:0] {
    no_operation_command = 3'h0,
    mode_set_command = 3'h1,
    read_cmd = 3'h2,
    write_cmd = 3'h3,
    long_impedance_calibration = 3'h4
  } cmd_t;

  typedef enum logic [1:0] {
    d_idle = 2'h0, d_rd_wait = 2'h1, d_rd_beat = 2'h3, d_wr_beat = 2'h2
  } dev_st_t;

  typedef enum logic [1:0] {c_idle = 2'h0, c_read = 2'h1, c_write = 2'h3} ctl_st_t;

  typedef struct packed {
    dev_st_t st;
    logic [`MODE_W-1:0] mode;
    logic [4:0] wait_cnt;
    logic [3:0] beat;
    logic [`COL_W-1:0] col;
    logic chop;
    logic [3:0] mod_cnt;
    logic [9:0] dll_cnt;
    logic dll_locked;
    logic pd;
    logic err;
    logic [`DQ_W-1:0] dq;
    logic dq_oe;
    logic dqs_oe;
  } dev_state_t;

  typedef struct packed {
    ctl_st_t st;
    logic [`MODE_W-1:0] mode;
    logic [2:0] ba;
    logic [`MODE_W-1:0] mr0_sent;
    logic [`COL_W-1:0] col;
    logic chop_sel;
    logic chop;
    logic [3:0] pend;
    logic cke_en;
    logic rst_rel;
    logic [63:0] wdata;
    logic [63:0] rdata;
    logic [3:0] mrs_cnt;
    logic [4:0] cmd_cnt;
    logic [3:0] mod_cnt;
    logic [9:0] dll_cnt;
    logic [3:0] pden_cnt;
    logic [3:0] beat;
    logic aph_valid;
    logic aph_write;
    logic [7:0] aph_addr;
    logic [31:0] hrdata;
    cmd_t cmd;
    logic [2:0] ba_o;
    logic [`ADDR_W-1:0] addr_o;
    logic cke;
    logic termination_control_input;
    logic [`DQ_W-1:0] dq;
    logic dq_oe;
  } ctl_state_t;

endpackage

// ---- pkg/sdram_link_if.sv ----
// command bus and data pins between controller and device
`include "sdram_mode_cfg.svh"
`timescale 1ns/100ps
interface sdram_link_if;
  import sdram_mode_pkg::*;
  logic cke;
  cmd_t cmd;
  logic [2:0] ba;
  logic [`ADDR_W-1:0] addr;
  logic termination_control_input;
  logic reset_pin_n;
  logic [`DQ_W-1:0] ctl_dq;
  logic ctl_dq_oe;
  logic ctl_dqs_oe;
  logic [`DQ_W-1:0] dev_dq;
  logic dev_dq_oe;
  logic dev_dqs_oe;
  wire [`DQ_W-1:0] dq;

  // shared data pins resolved from the two enables; released pins read low
  assign dq = dev_dq_oe ? dev_dq : (ctl_dq_oe ? ctl_dq : '0);

  modport device (
    input cke, cmd, ba, addr, termination_control_input, reset_pin_n, dq, ctl_dqs_oe,
    output dev_dq, dev_dq_oe, dev_dqs_oe
  );
  modport controller (
    output cke, cmd, ba, addr, termination_control_input, reset_pin_n, ctl_dq, ctl_dq_oe, ctl_dqs_oe,
    input dq, dev_dqs_oe
  );
endinterface

// ---- rtl/sdram_mode_device.sv ----
// device end: base mode register, burst ordering, read latency and column store
// How it works
// - mode register holds until rewritten or reset
// - controller sends every field each time
// - mode set only when idle and precharged
// - wait mode-to-mode gap between mode sets
// - only no-ops and mode sets until mode update interval
// - clock enable high until powerdown gap
// - latency change needs slow exit interval
// - termination input low through update interval
// - burst length field, on-the-fly chop select
// - chop bit 0 four beats, 1 eight
// - burst wraps inside aligned column block
// - burst type bit picks column order
// - sequential halves or start xor beat
// - chopped reads float last four slots
// - writes ignore low start column bits
// - dll reset bit clears itself
// - 512 cycles after dll reset before read
// - write recovery codes 5,6,7,8,10,12
// - powerdown bit keeps dll running
// - read latency 5 to 14 whole clocks; the decode also gives 4 and 15 to 19 for the other codes
// - first read beat at edge n+m
// - reserved mode bits written as zero
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`include "sdram_mode_cfg.svh"
`timescale 1ns/100ps
module sdram_mode_device (
  input logic hclk,
  input logic hresetn,
  sdram_link_if.device link,
  output logic [`MODE_W-1:0] mode_word,
  output logic [4:0] read_latency,
  output logic [3:0] write_recovery,
  output logic dll_locked,
  output logic dll_off_in_pd,
  output logic updating,
  output logic proto_err
);
  import sdram_mode_pkg::*;

  dev_state_t cur;
  dev_state_t nx;
  logic [`DQ_W-1:0] mem [0:(1 << `COL_W)-1];
  logic mem_we;
  logic [`COL_W-1:0] mem_wa;
  logic [`COL_W-1:0] beat_col;
  logic [3:0] cl_code;
  logic [4:0] lat;
  logic [1:0] bl;
  logic live;
  logic chop_now;

  // column within the eight-column block for beat i
  function automatic logic [2:0] col_order(input logic [2:0] start, input logic [2:0] i,
                                           input logic interleave);
    logic [2:0] r;
    if (interleave) begin
      r = start ^ i;
    end else begin
      r = {start[2] ^ i[2], 2'(start[1:0] + i[1:0])};
    end
    return r;
  endfunction

  function automatic logic [3:0] wr_decode(input logic [2:0] f);
    logic [3:0] r;
    case (f)
      3'h1: r = 4'h5;
      3'h2: r = 4'h6;
      3'h3: r = 4'h7;
      3'h4: r = 4'h8;
      3'h5: r = 4'hA;
      3'h6: r = 4'hC;
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  // latency code is mode bits 6:4 with bit 2 as the low bit
  assign cl_code = {cur.mode[`CL_MSB:`CL_LSB], cur.mode[`CL_LO_BIT]};
  assign lat = cl_code[0] ? 5'(5'h0C + {2'h0, cl_code[3:1]}) :
                            5'(5'h04 + {2'h0, cl_code[3:1]});
  assign bl = cur.mode[`BL_MSB:`BL_LSB];
  assign beat_col = {cur.col[`COL_W-1:3],
                     col_order(cur.col[2:0], cur.beat[2:0], cur.mode[`BT_BIT])};

  always_comb begin
    nx = cur;
    mem_we = 1'b0;
    mem_wa = '0;
    live = link.cke && link.reset_pin_n;
    // 00 fixed eight, 10 fixed chop, 01 chop picked per command
    chop_now = (bl == `BL_CHOP4) ||
               ((bl == `BL_OTF) && !link.addr[`CHOP_ADDR_BIT]);
    nx.pd = !link.cke;
    if (cur.mod_cnt != 4'h0) begin
      nx.mod_cnt = cur.mod_cnt - 4'h1;
    end
    if (cur.dll_cnt != 10'h000) begin
      nx.dll_cnt = cur.dll_cnt - 10'h001;
      if (cur.dll_cnt == 10'h001) begin
        nx.dll_locked = 1'b1;
      end
    end
    if (cur.mode[`DLL_RST_BIT]) begin
      nx.mode[`DLL_RST_BIT] = 1'b0;
    end
    if (live && cur.st != d_idle && link.cmd != no_operation_command) begin
      nx.err = 1'b1;
    end
    case (cur.st)
      d_idle: begin
        nx.dq_oe = 1'b0;
        nx.dqs_oe = 1'b0;
        if (live) begin
          if (link.cmd == mode_set_command) begin
            if (link.ba == 3'h0) begin
              nx.mode = link.addr;
              if (link.addr[`DLL_RST_BIT]) begin
                nx.dll_cnt = 10'(`DLLK_CK);
                nx.dll_locked = 1'b0;
              end
            end
            nx.mod_cnt = 4'(`MOD_CK);
          end else if (link.cmd != no_operation_command && cur.mod_cnt != 4'h0) begin
            nx.err = 1'b1;
          end else if (link.cmd == read_cmd) begin
            nx.col = link.addr[`COL_W-1:0];
            nx.chop = chop_now;
            nx.beat = 4'h0;
            nx.wait_cnt = lat - 5'h02;
            nx.st = d_rd_wait;
          end else if (link.cmd == write_cmd) begin
            nx.col = link.addr[`COL_W-1:0];
            nx.chop = chop_now;
            nx.beat = 4'h0;
            nx.st = d_wr_beat;
          end
        end
      end
      d_rd_wait: begin
        if (cur.wait_cnt == 5'h00) begin
          nx.dq = mem[beat_col];
          nx.dq_oe = 1'b1;
          nx.dqs_oe = 1'b1;
          nx.beat = 4'h1;
          nx.st = d_rd_beat;
        end else begin
          nx.wait_cnt = cur.wait_cnt - 5'h01;
        end
      end
      d_rd_beat: begin
        if (cur.beat == 4'h8) begin
          nx.dq_oe = 1'b0;
          nx.dqs_oe = 1'b0;
          nx.st = d_idle;
        end else begin
          nx.dq = mem[beat_col];
          nx.dq_oe = !(cur.chop && cur.beat[2]);
          nx.dqs_oe = !(cur.chop && cur.beat[2]);
          nx.beat = cur.beat + 4'h1;
        end
      end
      d_wr_beat: begin
        if (link.ctl_dqs_oe) begin
          mem_we = 1'b1;
          // start bits 1:0 are ignored on writes; bit 2 picks the half of a chopped burst
          mem_wa = {cur.col[`COL_W-1:3],
                    cur.chop ? {cur.col[2], cur.beat[1:0]} : cur.beat[2:0]};
          nx.beat = cur.beat + 4'h1;
          if (cur.beat == (cur.chop ? 4'h3 : 4'h7)) begin
            nx.st = d_idle;
          end
        end
      end
      default: begin
        nx.st = d_idle;
      end
    endcase
    if (!link.reset_pin_n) begin
      nx = '0;
      nx.mode = `MODE_RESET;
      nx.pd = !link.cke;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur <= '0;
    end else begin
      cur <= nx;
    end
  end

  // column store has no reset; array contents survive mode sets
  always_ff @(posedge hclk) begin
    if (mem_we) begin
      mem[mem_wa] <= link.dq;
    end
  end

  assign link.dev_dq = cur.dq;
  assign link.dev_dq_oe = cur.dq_oe;
  assign link.dev_dqs_oe = cur.dqs_oe;
  assign mode_word = cur.mode;
  assign read_latency = lat;
  assign write_recovery = wr_decode(cur.mode[`WR_MSB:`WR_LSB]);
  assign dll_locked = cur.dll_locked;
  assign dll_off_in_pd = cur.pd && !cur.mode[`PPD_BIT];
  assign updating = cur.mod_cnt != 4'h0;
  assign proto_err = cur.err;

endmodule // sdram_mode_device

// ---- rtl/sdram_mode_ctrl.sv ----
// controller end: AHB-Lite registers, command sequencing and data beats
`include "sdram_mode_cfg.svh"
`timescale 1ns/100ps
module sdram_mode_ctrl (
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input logic odt_request,
  sdram_link_if.controller link
);
  import sdram_mode_pkg::*;

  localparam int WRC = `WR_CK;
  localparam logic [2:0] WR_CODE = (WRC <= 5) ? 3'h1 : (WRC <= 8) ? 3'(WRC - 4) :
                                   (WRC <= 10) ? 3'h5 : 3'h6;

  ctl_state_t cur;
  ctl_state_t nx;
  logic [`MODE_W-1:0] word;
  logic [2:0] widx;
  logic ready_for_cmd;

  always_comb begin
    nx = cur;
    word = cur.mode;
    widx = cur.chop ? {cur.col[2], cur.beat[1:0]} : cur.beat[2:0];
    nx.cmd = no_operation_command;
    nx.dq_oe = 1'b0;
    if (cur.mrs_cnt != 4'h0) nx.mrs_cnt = cur.mrs_cnt - 4'h1;
    if (cur.cmd_cnt != 5'h00) nx.cmd_cnt = cur.cmd_cnt - 5'h01;
    if (cur.mod_cnt != 4'h0) nx.mod_cnt = cur.mod_cnt - 4'h1;
    if (cur.dll_cnt != 10'h000) nx.dll_cnt = cur.dll_cnt - 10'h001;
    if (cur.pden_cnt != 4'h0) nx.pden_cnt = cur.pden_cnt - 4'h1;
    nx.cke = cur.cke_en || cur.pden_cnt != 4'h0;
    if (nx.cke && !cur.cke) begin
      nx.cmd_cnt = cur.mr0_sent[`PPD_BIT] ? 5'(`XP_CK) : 5'(`XPDLL_CK);
    end
    nx.termination_control_input = odt_request && cur.mod_cnt == 4'h0;
    ready_for_cmd = cur.cke && nx.cke && cur.rst_rel && cur.st == c_idle;
    case (cur.st)
      c_idle: begin
        if (ready_for_cmd && cur.pend[`PEND_MRS] && cur.mrs_cnt == 4'h0) begin
          if (cur.ba == 3'h0) begin
            word = cur.mode & ~`RSVD_MASK;
            word[`WR_MSB:`WR_LSB] = WR_CODE;
            nx.mr0_sent = word;
            if (word[`DLL_RST_BIT]) nx.dll_cnt = 10'(`DLLK_CK);
          end
          nx.cmd = mode_set_command;
          nx.ba_o = cur.ba;
          nx.addr_o = word;
          nx.pend[`PEND_MRS] = 1'b0;
          nx.mrs_cnt = 4'(`MRD_CK);
          nx.mod_cnt = 4'(`MOD_CK);
          nx.pden_cnt = 4'(`MRSPDEN_CK);
          nx.termination_control_input = 1'b0;
          if (cur.ba == 3'h0 && {word[`CL_MSB:`CL_LSB], word[`CL_LO_BIT]} !=
              {cur.mr0_sent[`CL_MSB:`CL_LSB], cur.mr0_sent[`CL_LO_BIT]}) begin
            nx.cmd_cnt = 5'(`GAP_CL_CK);
          end else begin
            nx.cmd_cnt = 5'(`MOD_CK);
          end
        end else if (ready_for_cmd && cur.cmd_cnt == 5'h00 && cur.mod_cnt == 4'h0) begin
          if (cur.pend[`PEND_ZQ]) begin
            nx.cmd = long_impedance_calibration;
            nx.pend[`PEND_ZQ] = 1'b0;
            nx.cmd_cnt = 5'(`MOD_CK);
          end else if (cur.pend[`PEND_RD] && cur.dll_cnt == 10'h000) begin
            nx.cmd = read_cmd;
            nx.pend[`PEND_RD] = 1'b0;
            nx.st = c_read;
          end else if (cur.pend[`PEND_WR]) begin
            nx.cmd = write_cmd;
            nx.pend[`PEND_WR] = 1'b0;
            nx.st = c_write;
          end
          if (nx.st != c_idle) begin
            nx.addr_o = '0;
            nx.addr_o[`COL_W-1:0] = cur.col;
            nx.addr_o[`CHOP_ADDR_BIT] = cur.chop_sel;
            nx.ba_o = 3'h0;
            nx.beat = 4'h0;
            nx.chop = (cur.mr0_sent[`BL_MSB:`BL_LSB] == `BL_CHOP4) ||
                      ((cur.mr0_sent[`BL_MSB:`BL_LSB] == `BL_OTF) && !cur.chop_sel);
          end
        end
      end
      c_read: begin
        if (link.dev_dqs_oe || cur.beat != 4'h0) begin
          if (link.dev_dqs_oe) nx.rdata[{cur.beat[2:0], 3'h0} +: 8] = link.dq;
          nx.beat = cur.beat + 4'h1;
          if (cur.beat == 4'h7) begin
            nx.st = c_idle;
            nx.mrs_cnt = 4'(`RP_CK);
          end
        end
      end
      c_write: begin
        nx.dq = cur.wdata[{widx, 3'h0} +: 8];
        nx.dq_oe = 1'b1;
        nx.beat = cur.beat + 4'h1;
        if (cur.beat == (cur.chop ? 4'h3 : 4'h7)) begin
          nx.st = c_idle;
          nx.mrs_cnt = 4'(`RP_CK);
        end
      end
      default: nx.st = c_idle;
    endcase
    // bus write lands after the sequencer so a new request wins over its clear
    if (cur.aph_valid && cur.aph_write) begin
      case (cur.aph_addr)
        `OFF_MODE: begin
          nx.mode = hwdata[`MODE_W-1:0];
          nx.ba = hwdata[`MODE_BA_LSB +: 3];
        end
        `OFF_COL: begin
          nx.col = hwdata[`COL_W-1:0];
          nx.chop_sel = hwdata[`CHOP_ADDR_BIT];
        end
        `OFF_CTRL: begin
          nx.pend = nx.pend | hwdata[3:0];
          nx.cke_en = hwdata[`CTRL_CKE_BIT];
          nx.rst_rel = hwdata[`CTRL_RST_BIT];
        end
        `OFF_WLO: nx.wdata[31:0] = hwdata;
        `OFF_WHI: nx.wdata[63:32] = hwdata;
        default: nx.aph_valid = 1'b0;
      endcase
    end
    nx.aph_valid = hsel && hready && htrans[1];
    nx.aph_write = hwrite;
    nx.aph_addr = haddr[7:0];
    if (nx.aph_valid && !hwrite) begin
      case (haddr[7:0])
        `OFF_MODE: nx.hrdata = {9'h000, cur.ba, 1'b0, cur.mode};
        `OFF_COL: nx.hrdata = {19'h00000, cur.chop_sel, 6'h00, cur.col};
        `OFF_CTRL: nx.hrdata = {26'h0000000, cur.rst_rel, cur.cke_en, cur.pend};
        `OFF_STAT: nx.hrdata = {25'h0000000, cur.cmd_cnt != 5'h00, cur.dll_cnt != 10'h000,
                                cur.st != c_idle, cur.pend};
        `OFF_WLO: nx.hrdata = cur.wdata[31:0];
        `OFF_WHI: nx.hrdata = cur.wdata[63:32];
        `OFF_RLO: nx.hrdata = cur.rdata[31:0];
        `OFF_RHI: nx.hrdata = cur.rdata[63:32];
        default: nx.hrdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur <= '0;
    end else begin
      cur <= nx;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = cur.hrdata;
  assign link.cke = cur.cke;
  assign link.cmd = cur.cmd;
  assign link.ba = cur.ba_o;
  assign link.addr = cur.addr_o;
  assign link.termination_control_input = cur.termination_control_input;
  assign link.reset_pin_n = cur.rst_rel;
  assign link.ctl_dq = cur.dq;
  assign link.ctl_dq_oe = cur.dq_oe;
  assign link.ctl_dqs_oe = cur.dq_oe;

endmodule // sdram_mode_ctrl

// ---- tb/sdram_mode_properties.sv ----
// timing checker for the controller-to-device command link
`include "sdram_mode_cfg.svh"
`timescale 1ns/100ps
module sdram_mode_properties (
  input logic hclk,
  input logic hresetn,
  input logic cke,
  input sdram_mode_pkg::cmd_t cmd,
  input logic [2:0] ba,
  input logic [`ADDR_W-1:0] addr,
  input logic termination_control_input,
  input logic reset_pin_n,
  input logic ctl_dq_oe,
  input logic dev_dq_oe,
  input logic dev_dqs_oe
);
  import sdram_mode_pkg::*;
  logic [`MODE_W-1:0] mode_q;
  logic [4:0] rcnt;
  logic chop_q;
  logic [9:0] dll_cnt;
  logic [3:0] idle_cnt;
  wire ms = (cmd == mode_set_command);
  wire chop_now = (mode_q[1:0] == `BL_CHOP4) ||
                  (mode_q[1:0] == `BL_OTF && !addr[`CHOP_ADDR_BIT]);
  wire [4:0] lat = mode_q[`CL_LO_BIT] ? 5'h0C + {2'h0, mode_q[6:4]} : 5'h04 + {2'h0, mode_q[6:4]};

  // shadow of the mode word plus burst, dll and idle counters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= '0;
      rcnt <= 5'h00;
      chop_q <= 1'b0;
      dll_cnt <= 10'h000;
      idle_cnt <= 4'hF;
    end else begin
      if (!reset_pin_n) mode_q <= '0;
      else if (ms && ba == 3'h0) mode_q <= addr;
      if (cmd == read_cmd) rcnt <= 5'h01;
      else if (rcnt != 5'h00 && rcnt != 5'h1F) rcnt <= rcnt + 5'h01;
      if (cmd == read_cmd || cmd == write_cmd) chop_q <= chop_now;
      if (ms && ba == 3'h0 && addr[`DLL_RST_BIT]) dll_cnt <= 10'h001;
      else if (dll_cnt != 10'h000 && dll_cnt < 10'h258) dll_cnt <= dll_cnt + 10'h001;
      if (dev_dq_oe || ctl_dq_oe || dev_dqs_oe) idle_cnt <= 4'h0;
      else if (idle_cnt != 4'hF) idle_cnt <= idle_cnt + 4'h1;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_mode_gap: assert property (ms |=> !ms [*3])
    else $error("mode set repeated too soon");
  a_update_quiet: assert property (
    ms |=> (cmd inside {no_operation_command, mode_set_command}) [*8] ##1
      (cmd inside {no_operation_command, mode_set_command}) [*3])
    else $error("command inside mode update interval");
  a_cke_held: assert property (ms |-> cke [*8] ##1 cke [*4])
    else $error("clock enable dropped after mode set");
  a_odt_low: assert property (ms |-> !termination_control_input [*8] ##1 !termination_control_input [*4])
    else $error("termination high after mode set");
  a_field_fill: assert property ((ms && ba == 3'h0) |->
    (addr & `RSVD_MASK) == '0 && addr[`WR_MSB:`WR_LSB] == 3'h1)
    else $error("mode word fields wrong");
  a_idle_before: assert property (ms |-> idle_cnt >= 4'h2)
    else $error("mode set during or right after burst");
  a_dll_wait: assert property ((cmd == read_cmd) |->
    (dll_cnt == 10'h000 || dll_cnt >= 10'h200))
    else $error("read too soon after dll reset");
  a_read_first: assert property ((rcnt != 5'h00 && rcnt <= lat) |->
    (dev_dq_oe == (rcnt == lat)))
    else $error("first read beat at wrong edge");
  a_read_span: assert property ((rcnt >= lat && rcnt < lat + 5'h08) |->
    dev_dqs_oe == dev_dq_oe && dev_dq_oe == (!chop_q || rcnt < lat + 5'h04))
    else $error("read burst slots wrong");
  a_write_beats: assert property ((cmd == write_cmd) |=>
    ctl_dq_oe [*4] ##1 (ctl_dq_oe == !chop_q) [*4])
    else $error("write burst slots wrong");
endmodule // sdram_mode_properties

// ---- tb/tb_top.sv ----
// bench: controller and device joined, driven over the register bus
`include "sdram_mode_cfg.svh"
`timescale 1ns/100ps
module tb_top;
  import sdram_mode_pkg::*;
  logic hclk, hresetn, hsel, hwrite, odt_request;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire [31:0] hrdata;
  wire hreadyout, hresp, dll_locked, dll_off_in_pd, updating, proto_err;
  wire [`MODE_W-1:0] mode_word;
  wire [4:0] read_latency;
  wire [3:0] write_recovery;
  int bad_count, samples_checked;

  sdram_link_if link();
  sdram_mode_ctrl sdram_mode_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .odt_request(odt_request), .link(link));
  sdram_mode_device sdram_mode_device_inst (.hclk(hclk), .hresetn(hresetn), .link(link),
    .mode_word(mode_word), .read_latency(read_latency), .write_recovery(write_recovery),
    .dll_locked(dll_locked), .dll_off_in_pd(dll_off_in_pd), .updating(updating),
    .proto_err(proto_err));
  sdram_mode_properties sdram_mode_properties_inst (.hclk(hclk), .hresetn(hresetn),
    .cke(link.cke), .cmd(link.cmd), .ba(link.ba), .addr(link.addr), .termination_control_input(link.termination_control_input),
    .reset_pin_n(link.reset_pin_n), .ctl_dq_oe(link.ctl_dq_oe),
    .dev_dq_oe(link.dev_dq_oe), .dev_dqs_oe(link.dev_dqs_oe));

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  // post commands with clock enable and reset pin kept released, then wait idle
  task automatic issue(input logic [3:0] c);
    logic [31:0] q;
    int n;
    bus(1'b1, `OFF_CTRL, {26'h0, 2'h3, c}, q);
    n = 0;
    do begin
      bus(1'b0, `OFF_STAT, 32'h0, q);
      n++;
    end while (q[4:0] !== 5'h00 && n < 400);
    if (n >= 400) chk("status idle", 64'h0, {59'h0, q[4:0]});
  endtask

  task automatic set_mode(input logic [18:0] w);
    logic [31:0] q;
    bus(1'b1, `OFF_MODE, {13'h0, w}, q);
    issue(4'h1);
    // let the self-clearing dll bit settle before anyone looks
    repeat (2) @(posedge hclk);
  endtask

  task automatic xfer(input logic wrt, input logic full, input logic [5:0] col,
                      input logic [63:0] wd, output logic [63:0] rv);
    logic [31:0] q;
    bus(1'b1, `OFF_COL, {19'h0, full, 6'h0, col}, q);
    if (wrt) begin
      bus(1'b1, `OFF_WLO, wd[31:0], q);
      bus(1'b1, `OFF_WHI, wd[63:32], q);
      issue(4'h4);
    end else begin
      issue(4'h2);
      bus(1'b0, `OFF_RLO, 32'h0, q);
      rv[31:0] = q;
      bus(1'b0, `OFF_RHI, 32'h0, q);
      rv[63:32] = q;
    end
  endtask

  function automatic logic [2:0] ord(input logic [2:0] s, input logic [2:0] i, input logic il);
    ord = il ? s ^ i : {s[2] ^ i[2], s[1:0] + i[1:0]};
  endfunction

  task automatic conclude;
    $display("mismatches %0d comparisons %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #300000;
    bad_count++;
    $display("ERROR watchdog expected finish seen hang");
    conclude();
  end

  initial begin
    logic [31:0] q;
    logic [63:0] d, e, r;
    logic [18:0] w;
    logic [2:0] f;
    int k, s, i, il;
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    hsize = 3'h2;
    odt_request = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("mode after reset", 64'h0, mode_word);
    bus(1'b1, `OFF_CTRL, 32'h30, q);
    bus(1'b0, `OFF_CTRL, 32'h0, q);
    chk("control readback", 64'h30, q);
    bus(1'b0, 8'h40, 32'h0, q);
    chk("unmapped read", 64'h0, q);
    chk("bus response", 64'h0, hresp);
    for (k = 1; k <= 10; k++) begin
      f = (k > 7) ? 3'(k - 8) : 3'(k);
      w = 19'h4EE80 | {12'h0, f, 4'h0} | ((k > 7) ? 19'h00004 : 19'h0) |
          ((k == 1) ? 19'h00100 : 19'h0);
      set_mode(w);
      chk("mode word", (w & 19'h3107F) | 19'h00200, mode_word);
      chk("updating", 64'h1, updating);
      chk("read latency", 64'(k + 4), read_latency);
      chk("write recovery", 64'h5, write_recovery);
    end
    odt_request <= 1'b1;
    set_mode(19'h00010);
    d = 64'h8877665544332211;
    xfer(1'b1, 1'b1, 6'h0B, d, r);
    for (il = 0; il < 2; il++) begin
      set_mode(il[0] ? 19'h00018 : 19'h00010);
      for (s = 0; s < 8; s++) begin
        xfer(1'b0, 1'b1, {3'h1, s[2:0]}, d, r);
        for (i = 0; i < 8; i++) e[i*8 +: 8] = d[ord(s[2:0], i[2:0], il[0])*8 +: 8];
        chk("burst read", e, r);
      end
    end
    chk("dll locked", 64'h1, dll_locked);
    chk("update over", 64'h0, updating);
    set_mode(19'h00011);
    xfer(1'b1, 1'b0, 6'h0D, 64'hDDCCBBAA00000000, r);
    xfer(1'b0, 1'b0, 6'h0E, d, r);
    chk("chopped read", 64'hBBAADDCC, {32'h0, r[31:0]});
    xfer(1'b0, 1'b1, 6'h08, d, r);
    chk("full read", 64'hDDCCBBAA44332211, r);
    set_mode(19'h0001A);
    xfer(1'b0, 1'b1, 6'h09, d, r);
    chk("fixed chop read", 64'h33441122, {32'h0, r[31:0]});
    bus(1'b1, `OFF_MODE, 32'h00000010, q);
    issue(4'h9);
    chk("calibration quiet", 64'h0, proto_err);
    odt_request <= 1'b0;
    set_mode(19'h00010);
    bus(1'b1, `OFF_CTRL, 32'h20, q);
    repeat (16) @(posedge hclk);
    chk("dll off in power-down", 64'h1, dll_off_in_pd);
    bus(1'b1, `OFF_CTRL, 32'h30, q);
    set_mode(19'h01010);
    bus(1'b1, `OFF_CTRL, 32'h20, q);
    repeat (16) @(posedge hclk);
    chk("clock enable dropped", 64'h0, link.cke);
    chk("dll on in power-down", 64'h0, dll_off_in_pd);
    bus(1'b1, `OFF_CTRL, 32'h30, q);
    set_mode(19'h00010);
    chk("protocol error", 64'h0, proto_err);
    bus(1'b1, `OFF_CTRL, 32'h10, q);
    repeat (3) @(posedge hclk);
    chk("mode after reset pin", 64'h0, mode_word);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("mode after second reset", 64'h0, mode_word);
    conclude();
  end
endmodule // tb_top
